// ===== pkg/lss_pkg.sv
`default_nettype none
package lss_pkg;

    // ==========================================================
    // Frame identifiers and command codes
    localparam logic [10:0] LSS_ID_REQ      = 11'h7E5;
    localparam logic [10:0] LSS_ID_RSP      = 11'h7E4;
    localparam logic [3:0]  LSS_DLC         = 4'h8;
    localparam logic [7:0]  LSS_CS_ACT_BT   = 8'h51;
    localparam logic [7:0]  LSS_CS_STORE    = 8'h17;
    localparam logic [7:0]  LSS_CS_INQ_VEN  = 8'h5A;
    localparam logic [7:0]  LSS_CS_INQ_PRD  = 8'h5B;
    localparam logic [7:0]  LSS_CS_INQ_REV  = 8'h5C;
    localparam logic [7:0]  LSS_CS_INQ_SER  = 8'h5D;
    localparam logic [7:0]  LSS_CS_INQ_NID  = 8'h5E;
    localparam logic [7:0]  LSS_CS_ID_VEN   = 8'h46;
    localparam logic [7:0]  LSS_CS_ID_PRD   = 8'h47;
    localparam logic [7:0]  LSS_CS_ID_REVLO = 8'h48;
    localparam logic [7:0]  LSS_CS_ID_REVHI = 8'h49;
    localparam logic [7:0]  LSS_CS_ID_SERLO = 8'h4A;
    localparam logic [7:0]  LSS_CS_ID_SERHI = 8'h4B;
    localparam logic [7:0]  LSS_CS_ID_ANS   = 8'h4F;

    // ==========================================================
    // Result codes and factory defaults
    localparam logic [7:0]  LSS_ERR_NONE    = 8'h00;
    localparam logic [7:0]  LSS_ERR_NVM     = 8'h02;
    localparam logic [6:0]  LSS_NID_RESET   = 7'h7F;
    localparam logic [3:0]  LSS_BTI_RESET   = 4'h0;  // Table index 0 = 1000 kBd

    // ==========================================================
    // Timing
    localparam int          LSS_CLK_MHZ     = 250;
    localparam int          LSS_MS_US       = 1000;
    localparam int          LSS_CYC_PER_MS  = LSS_CLK_MHZ * LSS_MS_US;

    typedef enum logic [1:0] {
        LSS_ACT_IDLE,
        LSS_ACT_FIRST,
        LSS_ACT_SECOND
    } lss_act_t;

endpackage
`default_nettype wire

// ===== rtl/lss_delay.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Millisecond delay timer
module lss_delay
    import lss_pkg::*;
#(
    parameter int CYC_PER_MS = LSS_CYC_PER_MS
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [15:0] delay_ms,
    output logic             done
);
    logic [31:0] cyc_q;
    logic [15:0] ms_q;
    logic        run_q;
    wire         ms_tick  = run_q && (cyc_q == 32'(CYC_PER_MS - 1));
    wire         last_ms  = ms_tick && (ms_q <= 16'h0001);
    wire         zero_dly = start && (delay_ms == 16'h0000);

    assign done = last_ms || zero_dly;

    // Count cycles into milliseconds; zero delay completes at once
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cyc_q <= 32'h0000_0000;
            ms_q  <= 16'h0000;
            run_q <= 1'b0;
        end else if (start) begin
            cyc_q <= 32'h0000_0000;
            ms_q  <= delay_ms;
            run_q <= (delay_ms != 16'h0000);
        end else if (run_q) begin
            cyc_q <= ms_tick ? 32'h0000_0000 : cyc_q + 32'h0000_0001;
            ms_q  <= ms_tick ? ms_q - 16'h0001 : ms_q;
            run_q <= !last_ms;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/lss_slave_handler.sv
`timescale 1ns/1ps
`default_nettype none
module lss_slave_handler
    import lss_pkg::*;
#(
    parameter int          CYC_PER_MS = LSS_CYC_PER_MS,
    parameter logic [31:0] VENDOR_ID  = 32'h0000_1234,  // Arbitrary value
    parameter logic [31:0] PRODUCT_ID = 32'h0000_5678,  // Arbitrary value
    parameter logic [31:0] REVISION   = 32'h0001_0000,
    parameter logic [31:0] SERIAL     = 32'h0000_0001
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Received frame from the CAN controller
    input  wire logic        rx_valid,
    input  wire logic [10:0] rx_id,
    input  wire logic [3:0]  rx_dlc,
    input  wire logic [63:0] rx_data,
    // Mode and configuration from the surrounding slave logic
    input  wire logic        cfg_mode,
    input  wire logic [6:0]  pend_nid,
    input  wire logic [3:0]  pend_bti,
    input  wire logic [6:0]  stored_nid,
    input  wire logic [3:0]  stored_bti,
    input  wire logic        stored_valid,
    // Non-volatile storage port
    output logic             nvm_wr,
    output logic [6:0]       nvm_nid,
    output logic [3:0]       nvm_bti,
    input  wire logic        nvm_done,
    input  wire logic        nvm_fail,
    // Response frame to the CAN controller
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [10:0]      tx_id,
    output logic [3:0]       tx_dlc,
    output logic [63:0]      tx_data,
    output logic             tx_inhibit,
    // Operating configuration
    output logic [6:0]       node_id,
    output logic [3:0]       bit_rate_idx,
    output logic             rate_switch
);

    // ==========================================================
    // Frame decode
    wire        frame_ok = rx_valid && (rx_id == LSS_ID_REQ) && (rx_dlc == LSS_DLC);
    wire [7:0]  rx_cs    = rx_data[7:0];
    wire [31:0] rx_word  = rx_data[39:8];
    wire [15:0] rx_delay = rx_data[23:8];
    wire        rest_nul = (rx_data[63:8] == 56'h0);
    wire        acc      = frame_ok && cfg_mode;

    wire        is_act   = frame_ok && (rx_cs == LSS_CS_ACT_BT);
    wire        is_store = acc && (rx_cs == LSS_CS_STORE) && rest_nul;
    wire        is_inq   = acc && (rx_cs >= LSS_CS_INQ_VEN) && (rx_cs <= LSS_CS_INQ_NID);
    wire        is_id    = frame_ok && (rx_cs >= LSS_CS_ID_VEN) && (rx_cs <= LSS_CS_ID_SERHI);

    // ==========================================================
    // Identification criteria and match
    logic [31:0] ven_q, prd_q, rlo_q, rhi_q, slo_q, shi_q;
    wire         id_match = (VENDOR_ID == ven_q) && (PRODUCT_ID == prd_q)
                         && (REVISION >= rlo_q) && (REVISION <= rhi_q)
                         && (SERIAL >= slo_q) && (SERIAL <= shi_q);
    wire         id_fire  = frame_ok && (rx_cs == LSS_CS_ID_SERHI);

    // Criteria latch on their own command codes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ven_q <= 32'h0000_0000;
            prd_q <= 32'h0000_0000;
            rlo_q <= 32'hFFFF_FFFF;
            rhi_q <= 32'h0000_0000;
            slo_q <= 32'hFFFF_FFFF;
            shi_q <= 32'h0000_0000;
        end else if (is_id) begin
            case (rx_cs)
                LSS_CS_ID_VEN:   ven_q <= rx_word;
                LSS_CS_ID_PRD:   prd_q <= rx_word;
                LSS_CS_ID_REVLO: rlo_q <= rx_word;
                LSS_CS_ID_REVHI: rhi_q <= rx_word;
                LSS_CS_ID_SERLO: slo_q <= rx_word;
                LSS_CS_ID_SERHI: shi_q <= rx_word;
                default:         ven_q <= ven_q;
            endcase
        end
    end

    // Match uses the serial upper bound just arriving
    wire id_hit = id_fire && (VENDOR_ID == ven_q) && (PRODUCT_ID == prd_q)
               && (REVISION >= rlo_q) && (REVISION <= rhi_q)
               && (SERIAL >= slo_q) && (SERIAL <= rx_word);

    // ==========================================================
    // Operating configuration, taken from storage only at reset
    logic [6:0] nid_q;
    logic [3:0] bti_q;
    logic       boot_q;

    // Stored values are sampled once after release, defaults otherwise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nid_q  <= LSS_NID_RESET;
            bti_q  <= LSS_BTI_RESET;
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
            if (boot_q && stored_valid) begin
                nid_q <= stored_nid;
                bti_q <= stored_bti;
            end else if (rate_switch) begin
                bti_q <= pend_bti;
            end
        end
    end
    assign node_id      = nid_q;
    assign bit_rate_idx = bti_q;

    // ==========================================================
    // Activate bit timing: two equal delays
    lss_act_t    act_q, act_d;
    logic [15:0] dly_q;
    logic        tmr_start;
    logic        tmr_done;

    lss_delay #(
        .CYC_PER_MS (CYC_PER_MS)
    ) lss_delay_inst (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .start    (tmr_start),
        .delay_ms (is_act && act_q == LSS_ACT_IDLE ? rx_delay : dly_q),
        .done     (tmr_done)
    );

    // Second start is issued when the first interval ends
    always_comb begin
        act_d       = act_q;
        tmr_start   = 1'b0;
        rate_switch = 1'b0;
        case (act_q)
            LSS_ACT_IDLE: begin
                if (is_act) begin
                    tmr_start = 1'b1;
                    rate_switch = tmr_done;
                    act_d     = tmr_done ? LSS_ACT_SECOND : LSS_ACT_FIRST;
                end
            end
            LSS_ACT_FIRST: begin
                if (tmr_done) begin
                    rate_switch = 1'b1;
                    tmr_start   = 1'b1;
                    act_d       = LSS_ACT_SECOND;
                end
            end
            LSS_ACT_SECOND: begin
                if (tmr_done || dly_q == 16'h0000) begin  // Zero delay issues no second timer start
                    act_d = LSS_ACT_IDLE;
                end
            end
            default: act_d = LSS_ACT_IDLE;
        endcase
    end

    // Delay is kept for the second interval
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            act_q <= LSS_ACT_IDLE;
            dly_q <= 16'h0000;
        end else begin
            act_q <= act_d;
            if (is_act && act_q == LSS_ACT_IDLE) begin
                dly_q <= rx_delay;
            end
        end
    end

    // Transmitter is held off across both intervals
    assign tx_inhibit = (act_q != LSS_ACT_IDLE);

    // ==========================================================
    // Store request towards non-volatile memory
    logic nvm_busy_q;
    logic nvm_wr_q;
    logic [6:0] nvm_nid_q;
    logic [3:0] nvm_bti_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nvm_busy_q <= 1'b0;
            nvm_wr_q   <= 1'b0;
            nvm_nid_q  <= LSS_NID_RESET;
            nvm_bti_q  <= LSS_BTI_RESET;
        end else begin
            nvm_wr_q <= is_store && !nvm_busy_q;
            if (is_store && !nvm_busy_q) begin
                nvm_busy_q <= 1'b1;
                nvm_nid_q  <= pend_nid;
                nvm_bti_q  <= pend_bti;
            end else if (nvm_done) begin
                nvm_busy_q <= 1'b0;
            end
        end
    end
    assign nvm_wr  = nvm_wr_q;
    assign nvm_nid = nvm_nid_q;
    assign nvm_bti = nvm_bti_q;

    // ==========================================================
    // Response builder
    logic [63:0] rsp_d;
    logic        rsp_new;
    logic [63:0] tx_data_q;
    logic        tx_valid_q;

    // Select the reply; unknown codes produce nothing
    always_comb begin
        rsp_d   = 64'h0;
        rsp_new = 1'b0;
        if (nvm_busy_q && nvm_done) begin
            rsp_new = 1'b1;
            rsp_d   = {48'h0, nvm_fail ? LSS_ERR_NVM : LSS_ERR_NONE, LSS_CS_STORE};
        end else if (is_inq) begin
            rsp_new = 1'b1;
            case (rx_cs)
                LSS_CS_INQ_VEN: rsp_d = {24'h0, VENDOR_ID, rx_cs};
                LSS_CS_INQ_PRD: rsp_d = {24'h0, PRODUCT_ID, rx_cs};
                LSS_CS_INQ_REV: rsp_d = {24'h0, REVISION, rx_cs};
                LSS_CS_INQ_SER: rsp_d = {24'h0, SERIAL, rx_cs};
                LSS_CS_INQ_NID: rsp_d = {48'h0, 1'b0, nid_q, rx_cs};
                default:        rsp_new = 1'b0;
            endcase
        end else if (id_hit) begin
            rsp_new = 1'b1;
            rsp_d   = {56'h0, LSS_CS_ID_ANS};
        end
    end

    // One-deep holding slot; a newer reply replaces an unsent one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_valid_q <= 1'b0;
            tx_data_q  <= 64'h0;
        end else if (rsp_new) begin
            tx_valid_q <= 1'b1;
            tx_data_q  <= rsp_d;
        end else if (tx_valid_q && tx_ready && !tx_inhibit) begin
            tx_valid_q <= 1'b0;
        end
    end

    assign tx_valid = tx_valid_q && !tx_inhibit;
    assign tx_data  = tx_data_q;
    assign tx_id    = LSS_ID_RSP;
    assign tx_dlc   = LSS_DLC;

    // ==========================================================
    // Checks
    a_inhibit_blocks_tx: assert property (@(posedge sys_clk) disable iff (rst)
        tx_inhibit |-> !tx_valid)
        else $error("frame offered during bit rate delay");
    a_switch_then_wait: assert property (@(posedge sys_clk) disable iff (rst)
        rate_switch |=> (act_q == LSS_ACT_SECOND) && tx_inhibit)
        else $error("second delay not started after switch");
    a_rate_takes_pend: assert property (@(posedge sys_clk) disable iff (rst)
        rate_switch && !boot_q |=> bit_rate_idx == $past(pend_bti))
        else $error("bit rate not taken on switch");
    a_store_writes: assert property (@(posedge sys_clk) disable iff (rst)
        is_store && !nvm_busy_q |=> nvm_wr && nvm_nid == $past(pend_nid))
        else $error("store did not write node id");
    a_store_reply: assert property (@(posedge sys_clk) disable iff (rst)
        nvm_busy_q && nvm_done
        |=> tx_data[15:0] == {($past(nvm_fail) ? LSS_ERR_NVM : LSS_ERR_NONE), LSS_CS_STORE})
        else $error("store reply wrong");
    a_vendor_reply: assert property (@(posedge sys_clk) disable iff (rst)
        is_inq && rx_cs == LSS_CS_INQ_VEN && !(nvm_busy_q && nvm_done)
        |=> tx_data == {24'h0, VENDOR_ID, LSS_CS_INQ_VEN})
        else $error("vendor inquiry reply wrong");
    a_nid_reply: assert property (@(posedge sys_clk) disable iff (rst)
        is_inq && rx_cs == LSS_CS_INQ_NID && !(nvm_busy_q && nvm_done)
        |=> tx_data[15:8] == {1'b0, node_id} && tx_data[63:16] == 48'h0)
        else $error("node id reply wrong");
    a_wait_mode_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        frame_ok && !cfg_mode && !id_hit && !(nvm_busy_q && nvm_done) |=> !$rose(tx_valid_q))
        else $error("reply in wait mode");
    a_ident_frame: assert property (@(posedge sys_clk) disable iff (rst)
        id_hit && !is_inq && !(nvm_busy_q && nvm_done) |=> tx_data == {56'h0, LSS_CS_ID_ANS})
        else $error("identify frame wrong");
    a_response_id: assert property (@(posedge sys_clk) disable iff (rst)
        tx_valid |-> tx_id == LSS_ID_RSP && tx_dlc == LSS_DLC)
        else $error("response id or length wrong");
    a_match_steady: assert property (@(posedge sys_clk) disable iff (rst)
        id_hit |=> id_match)
        else $error("identify without match");

endmodule
`default_nettype wire

// ===== verification/lss_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side model: storage memory and frame consumer
module lss_master_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic nvm_wr,
    input  wire logic fail,
    input  wire logic stall,
    output logic      nvm_done,
    output logic      nvm_fail,
    output logic      tx_ready
);
    logic [1:0] cnt_q;

    // Storage answers three cycles after a write, never at once
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 2'h0;
        end else if (nvm_wr) begin
            cnt_q <= 2'h3;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end

    // Result only valid with done; inverted otherwise to expose sloppy sampling
    assign nvm_done = (cnt_q == 2'h1);
    assign nvm_fail = nvm_done ? fail : ~fail;
    // Consumer of 8-byte frames on the response identifier
    assign tx_ready = ~stall;
endmodule
`default_nettype wire

// ===== verification/lss_slave_handler_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the slave service handler
module lss_slave_handler_test
    import lss_pkg::*;
;
    localparam logic [31:0] VEN = 32'h0000_00A1; // Arbitrary value
    localparam logic [31:0] PRD = 32'h0000_00B2; // Arbitrary value
    localparam logic [31:0] REV = 32'h0003_0000;
    localparam logic [31:0] SER = 32'h0000_0100;
    typedef struct {logic [10:0] id; logic cfg; logic [63:0] rx; logic tx; logic [63:0] txd;} lss_row_t;

    logic        sys_clk = 1'b0, rst = 1'b1, rx_valid = 1'b0, cfg_mode = 1'b1;
    logic [10:0] rx_id = LSS_ID_REQ, tx_id;
    logic [3:0]  rx_dlc = LSS_DLC, pend_bti = 4'h4, stored_bti = 4'h4, nvm_bti, tx_dlc, bit_rate_idx;
    logic [63:0] rx_data = 64'h0, tx_data;
    logic [6:0]  pend_nid = 7'h05, stored_nid = 7'h05, nvm_nid, node_id;
    logic        stored_valid = 1'b0, nvm_wr, nvm_done, nvm_fail, tx_valid, tx_ready;
    logic        tx_inhibit, rate_switch, fail = 1'b0, stall = 1'b0;
    int          err_count = 0, samples_checked = 0, cyc = 0, n;
    lss_row_t    rows [15];

    always #2 sys_clk = ~sys_clk;

    lss_slave_handler #(.CYC_PER_MS(10), .VENDOR_ID(VEN), .PRODUCT_ID(PRD), .REVISION(REV), .SERIAL(SER))
    lss_slave_handler_inst (
        .sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc),
        .rx_data(rx_data), .cfg_mode(cfg_mode), .pend_nid(pend_nid), .pend_bti(pend_bti),
        .stored_nid(stored_nid), .stored_bti(stored_bti), .stored_valid(stored_valid),
        .nvm_wr(nvm_wr), .nvm_nid(nvm_nid), .nvm_bti(nvm_bti), .nvm_done(nvm_done),
        .nvm_fail(nvm_fail), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
        .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_inhibit(tx_inhibit), .node_id(node_id),
        .bit_rate_idx(bit_rate_idx), .rate_switch(rate_switch)
    );

    lss_master_model lss_master_model_inst (
        .sys_clk(sys_clk), .rst(rst), .nvm_wr(nvm_wr), .fail(fail), .stall(stall),
        .nvm_done(nvm_done), .nvm_fail(nvm_fail), .tx_ready(tx_ready)
    );

    // ==========================================================
    // Helpers
    function automatic logic [63:0] frm(input logic [7:0] cs, input logic [31:0] w);
        return {24'h00_0000, w, cs};
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One frame, pulse of one cycle; returns 1 ns after the taking edge
    task automatic send(input logic [10:0] id, input logic [63:0] d);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_id    <= id;
        rx_data  <= d;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        #1;
    endtask

    task automatic wait_tx();
        n = 0;
        while (tx_valid !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard, well above the hundred or so cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_of_test();
        end
    end

    // ==========================================================
    // Main sequence; one slave, in waiting mode for some table rows and in configuration mode otherwise
    initial begin
        rows = '{
            '{LSS_ID_REQ, 1'b1, frm(8'h5A, 0), 1'b1, frm(8'h5A, VEN)},
            '{LSS_ID_REQ, 1'b1, frm(8'h5B, 0), 1'b1, frm(8'h5B, PRD)},
            '{LSS_ID_REQ, 1'b1, frm(8'h5C, 0), 1'b1, frm(8'h5C, REV)},
            '{LSS_ID_REQ, 1'b1, frm(8'h5D, 0), 1'b1, frm(8'h5D, SER)},
            '{LSS_ID_REQ, 1'b1, frm(8'h5E, 0), 1'b1, frm(8'h5E, 32'h7F)},
            '{LSS_ID_REQ, 1'b0, frm(8'h5A, 0), 1'b0, 64'h0},
            '{LSS_ID_REQ, 1'b1, frm(8'h99, 0), 1'b0, 64'h0},
            '{LSS_ID_RSP, 1'b1, frm(8'h5A, 0), 1'b0, 64'h0},
            '{LSS_ID_REQ, 1'b0, frm(8'h46, VEN), 1'b0, 64'h0},
            '{LSS_ID_REQ, 1'b0, frm(8'h47, PRD), 1'b0, 64'h0},
            '{LSS_ID_REQ, 1'b0, frm(8'h48, REV), 1'b0, 64'h0},
            '{LSS_ID_REQ, 1'b0, frm(8'h49, REV), 1'b0, 64'h0},
            '{LSS_ID_REQ, 1'b0, frm(8'h4A, SER), 1'b0, 64'h0},
            '{LSS_ID_REQ, 1'b0, frm(8'h4B, SER), 1'b1, frm(8'h4F, 0)},
            '{LSS_ID_REQ, 1'b0, frm(8'h4B, SER - 1), 1'b0, 64'h0}
        };
        repeat (5) @(posedge sys_clk);
        #1;
        chk(node_id, 7'h7F);
        chk(bit_rate_idx, LSS_BTI_RESET);
        @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 15; i++) begin
            cfg_mode <= rows[i].cfg;
            send(rows[i].id, rows[i].rx);
            chk(tx_valid, rows[i].tx);
            if (rows[i].tx) begin
                chk(tx_data, rows[i].txd);
                chk({tx_id, tx_dlc}, {LSS_ID_RSP, LSS_DLC});
            end
        end
        cfg_mode <= 1'b1;
        $display("table done");
        // Reply stands while the consumer stalls
        stall <= 1'b1;
        send(LSS_ID_REQ, frm(8'h5B, 0));
        repeat (3) @(posedge sys_clk);
        #1;
        chk(tx_valid, 1'b1);
        chk(tx_data, frm(8'h5B, PRD));
        stall <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(tx_valid, 1'b0);
        $display("stall done");
        // Store, good then failed, back to operating values unchanged
        for (int k = 0; k < 2; k++) begin
            fail <= k[0];
            send(LSS_ID_REQ, frm(LSS_CS_STORE, 0));
            chk({nvm_wr, nvm_nid, nvm_bti}, {1'b1, 7'h05, 4'h4});
            wait_tx();
            chk(tx_data, frm(LSS_CS_STORE, k[0] ? 32'h02 : 32'h00));
            chk({node_id, bit_rate_idx}, {7'h7F, 4'h0});
        end
        fail <= 1'b0;
        $display("store done");
        // Activate with a 2 ms delay, inquiry held back during the second interval
        pend_bti <= 4'h3;
        send(LSS_ID_REQ, {40'h0, 16'h0002, LSS_CS_ACT_BT});
        chk(tx_inhibit, 1'b1);
        n = 0;
        while (rate_switch !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(n >= 19 && n <= 21, 1'b1);
        chk(bit_rate_idx, 4'h0);
        send(LSS_ID_REQ, frm(8'h5E, 0));
        chk({tx_inhibit, tx_valid}, 2'b10);
        chk(bit_rate_idx, 4'h3);
        n = 2;
        while (tx_inhibit !== 1'b0 && n < 100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(n >= 19 && n <= 21, 1'b1);
        chk(tx_valid, 1'b1);
        chk(tx_data, frm(LSS_CS_INQ_NID, 32'h7F));
        repeat (4) @(posedge sys_clk);
        // Zero delay: switch at once, inhibit for one cycle only
        pend_bti <= 4'h6;
        send(LSS_ID_REQ, {40'h0, 16'h0000, LSS_CS_ACT_BT});
        chk({tx_inhibit, bit_rate_idx}, {1'b1, 4'h6});
        @(posedge sys_clk);
        #1;
        chk(tx_inhibit, 1'b0);
        $display("activate done");
        // Restart with stored contents
        stored_valid <= 1'b1;
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({node_id, bit_rate_idx}, {7'h05, 4'h4});
        $display("restart done");
        end_of_test();
    end
endmodule
`default_nettype wire
